/* verilog/cbt_pkg.sv */
// shared constants and types of the can bit timing block
`default_nettype none

package cbt_pkg;

  // register byte offsets on the wishbone slave
  localparam int unsigned CBT_ADR_W = 4;
  localparam logic [3:0] CBT_OFS_CFG1 = 4'h0;
  localparam logic [3:0] CBT_OFS_CFG2 = 4'h4;
  localparam logic [3:0] CBT_OFS_CTRL = 4'h8;
  localparam logic [3:0] CBT_OFS_STAT = 4'hC;

  // first_timing_config_register fields
  localparam int unsigned CBT_PRESC_LSB = 0;
  localparam int unsigned CBT_PRESC_W = 6;
  localparam int unsigned CBT_SJW_LSB = 6;
  localparam int unsigned CBT_SJW_W = 2;
  localparam int unsigned CBT_CFG1_W = 8;

  // second_timing_config_register fields
  localparam int unsigned CBT_SEG_W = 3;
  localparam int unsigned CBT_PROP_LSB = 0;
  localparam int unsigned CBT_PH1_LSB = 3;
  localparam int unsigned CBT_SAM_BIT = 6;
  localparam int unsigned CBT_PH2SEL_BIT = 7;
  localparam int unsigned CBT_PH2_LSB = 8;
  localparam int unsigned CBT_CFG2_W = 11;

  // control register: module_clock_source_select
  localparam int unsigned CBT_SRC_BIT = 0;

  // status register bit positions
  localparam int unsigned CBT_ST_BIT = 0;
  localparam int unsigned CBT_ST_RX = 1;
  localparam int unsigned CBT_ST_SEG_LSB = 2;
  localparam int unsigned CBT_ST_HS = 4;
  localparam int unsigned CBT_ST_RSD = 5;

  // reset values
  localparam logic [7:0] CBT_CFG1_RST = 8'h00;
  localparam logic [10:0] CBT_CFG2_RST = 11'h000;
  localparam logic CBT_SRC_RST = 1'b0;

  // timing constants, in full clocks or quanta
  localparam logic [1:0] CBT_FCY_LAST = 2'h3;
  localparam logic [3:0] CBT_PROC_TQ = 4'h2;
  localparam logic [3:0] CBT_ONE_TQ = 4'h1;

  typedef enum logic [1:0] {
    CBT_SEG_SYNC,
    CBT_SEG_PROP,
    CBT_SEG_PH1,
    CBT_SEG_PH2
  } cbt_seg_e;

endpackage

`default_nettype wire

/* verilog/cbt_rx_sampler.sv */
// receive pin synchroniser, edge detector and three-sample majority vote
`default_nettype none

module cbt_rx_sampler
  import cbt_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // pin and timing
  input wire logic rx_pin_in,
  input wire logic half_tick_in,
  // results
  output logic rx_now_out,
  output logic fall_edge_out,
  output logic vote_out
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic h1;
    logic h2;
  } cbt_smp_s;

  cbt_smp_s s_r;
  cbt_smp_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = rx_pin_in;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev = s_r.sync2;
    // history one and two half quanta back from the current level
    if (half_tick_in) begin
      s_nxt.h1 = s_r.sync2;
      s_nxt.h2 = s_r.h1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_r <= '1;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  assign rx_now_out = s_r.sync2;
  // recessive is high, so a start edge is a fall
  assign fall_edge_out = s_r.prev & ~s_r.sync2;
  assign vote_out = (s_r.sync2 & s_r.h1) | (s_r.sync2 & s_r.h2) |
                    (s_r.h1 & s_r.h2);

endmodule

`default_nettype wire

/* verilog/cbt_bit_timing.sv */
// can bit timing logic with wishbone register slave
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`default_nettype none

module cbt_bit_timing
  import cbt_pkg::*;
(
  // clock, reset and enable
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  // wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [CBT_ADR_W-1:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // can bus side and frame logic
  input wire logic CAN_RX_IN,
  input wire logic BUS_IDLE_IN,
  output logic SAMPLE_BIT_OUT,
  output logic SAMPLE_STROBE_OUT,
  output logic BIT_START_OUT,
  output logic TQ_TICK_OUT,
  output logic HARD_SYNC_OUT
);

  typedef struct packed {
    logic [CBT_CFG1_W-1:0] cfg1;
    logic [CBT_CFG2_W-1:0] cfg2;
    logic src_sel;
    logic ack;
    logic [31:0] dat;
    logic [1:0] div;
    logic [CBT_PRESC_W-1:0] presc;
    logic half_ph;
    cbt_seg_e seg;
    logic [3:0] cnt;
    logic [2:0] ext;
    logic [2:0] shrink;
    logic hs_bit;
    logic rs_done;
    logic bit_val;
    logic sample_stb;
    logic bit_start;
    logic tq_tick;
    logic hard_sync;
  } cbt_state_s;

  cbt_state_s s_r;
  cbt_state_s s_nxt;

  logic rx_now;
  logic fall_edge;
  logic vote;
  logic half_tick;

  cbt_rx_sampler u_sampler (
    .clk_in(CLOCK_IN),
    .arst_n_in(ARST_N_IN),
    .ce_in(CE_IN),
    .rx_pin_in(CAN_RX_IN),
    .half_tick_in(half_tick),
    .rx_now_out(rx_now),
    .fall_edge_out(fall_edge),
    .vote_out(vote)
  );

  // decoded configuration
  logic [CBT_PRESC_W-1:0] presc_val;
  logic [3:0] prop_len;
  logic [3:0] ph1_len;
  logic [3:0] ph2_prog;
  logic [3:0] ph2_base;
  logic [3:0] ph1_eff;
  logic [3:0] ph2_eff;
  logic [4:0] sjw_len;
  logic mod_ce;
  logic tq;
  logic wb_req;

  always_comb begin
    presc_val = s_r.cfg1[CBT_PRESC_LSB +: CBT_PRESC_W];
    sjw_len = {3'h0, s_r.cfg1[CBT_SJW_LSB +: CBT_SJW_W]} + 5'h01;
    prop_len = {1'b0, s_r.cfg2[CBT_PROP_LSB +: CBT_SEG_W]} + 4'h1;
    ph1_len = {1'b0, s_r.cfg2[CBT_PH1_LSB +: CBT_SEG_W]} + 4'h1;
    ph2_prog = {1'b0, s_r.cfg2[CBT_PH2_LSB +: CBT_SEG_W]} + 4'h1;
    // phase two follows phase one, never below 2 quanta, unless programmed
    if (s_r.cfg2[CBT_PH2SEL_BIT]) begin
      ph2_base = ph2_prog;
    end else if (ph1_len > CBT_PROC_TQ) begin
      ph2_base = ph1_len;
    end else begin
      ph2_base = CBT_PROC_TQ;
    end
    ph1_eff = ph1_len + {1'b0, s_r.ext};
    ph2_eff = ph2_base - {1'b0, s_r.shrink};
    // module clock is the full clock, or a quarter of it
    mod_ce = ~s_r.src_sel | (s_r.div == CBT_FCY_LAST);
    half_tick = mod_ce & (s_r.presc == presc_val);
    tq = half_tick & s_r.half_ph;
    wb_req = WB_CYC_IN & WB_STB_IN;
  end

  // a request is read on its first cycle and written on its ack cycle
  logic rd_take;
  logic wr_take;

  always_comb begin
    rd_take = wb_req & ~s_r.ack;
    wr_take = wb_req & WB_WE_IN & s_r.ack;
  end

  // status word, polled by software
  logic [31:0] stat_word;

  always_comb begin
    stat_word = 32'h00000000;
    stat_word[CBT_ST_BIT] = s_r.bit_val;
    stat_word[CBT_ST_RX] = rx_now;
    stat_word[CBT_ST_SEG_LSB +: $bits(cbt_seg_e)] = s_r.seg;
    stat_word[CBT_ST_HS] = s_r.hs_bit;
    stat_word[CBT_ST_RSD] = s_r.rs_done;
  end

  // read data is chosen here and registered when the request is taken
  logic [31:0] rd_word;

  always_comb begin
    case (WB_ADR_IN)
      CBT_OFS_CFG1: rd_word = {24'h000000, s_r.cfg1};
      CBT_OFS_CFG2: rd_word = {21'h000000, s_r.cfg2};
      CBT_OFS_CTRL: rd_word = {31'h00000000, s_r.src_sel};
      CBT_OFS_STAT: rd_word = stat_word;
      default: rd_word = 32'h00000000;
    endcase
  end

  // phase error, in quanta since the end of the sync segment
  logic [4:0] err;
  logic [4:0] left;
  logic [2:0] adj;
  logic early_end;

  always_comb begin
    err = 5'h00;
    left = 5'h00;
    early_end = 1'b0;
    case (s_r.seg)
      CBT_SEG_PROP: begin
        err = {1'b0, s_r.cnt} + 5'h01;
      end
      CBT_SEG_PH1: begin
        err = {1'b0, prop_len} + {1'b0, s_r.cnt} + 5'h01;
      end
      CBT_SEG_PH2: begin
        left = {1'b0, ph2_eff} - {1'b0, s_r.cnt};
        // edge close enough to the bit end to open the next bit at once
        early_end = (left <= sjw_len);
      end
      default: ; // edge inside sync: no phase error
    endcase
    // lengthening never goes past the jump width
    adj = (err < sjw_len) ? err[2:0] : sjw_len[2:0];
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.sample_stb = 1'b0;
    s_nxt.bit_start = 1'b0;
    s_nxt.tq_tick = 1'b0;
    s_nxt.hard_sync = 1'b0;

    // wishbone: answer one cycle after the request, write on the ack edge
    s_nxt.ack = rd_take;
    if (rd_take) begin
      s_nxt.dat = rd_word;
    end
    if (wr_take) begin
      case (WB_ADR_IN)
        CBT_OFS_CFG1: begin
          if (WB_SEL_IN[0]) begin
            s_nxt.cfg1 = WB_DAT_IN[CBT_CFG1_W-1:0];
          end
        end
        CBT_OFS_CFG2: begin
          if (WB_SEL_IN[0]) begin
            s_nxt.cfg2[7:0] = WB_DAT_IN[7:0];
          end
          if (WB_SEL_IN[1]) begin
            s_nxt.cfg2[CBT_CFG2_W-1:8] = WB_DAT_IN[CBT_CFG2_W-1:8];
          end
        end
        CBT_OFS_CTRL: begin
          if (WB_SEL_IN[0]) begin
            s_nxt.src_sel = WB_DAT_IN[CBT_SRC_BIT];
          end
        end
        default: ;
      endcase
    end

    // clock division down to half quanta
    s_nxt.div = s_r.div + 2'h1;
    if (half_tick) begin
      s_nxt.presc = '0;
      s_nxt.half_ph = ~s_r.half_ph;
    end else if (mod_ce) begin
      s_nxt.presc = s_r.presc + 6'h01;
    end
    s_nxt.tq_tick = tq;

    // segment sequencer, one step per quantum
    if (tq) begin
      s_nxt.cnt = s_r.cnt + 4'h1;
      case (s_r.seg)
        CBT_SEG_SYNC: begin
          if (s_r.cnt == CBT_ONE_TQ - 4'h1) begin
            s_nxt.seg = CBT_SEG_PROP;
            s_nxt.cnt = 4'h0;
          end
        end
        CBT_SEG_PROP: begin
          if (s_r.cnt == prop_len - 4'h1) begin
            s_nxt.seg = CBT_SEG_PH1;
            s_nxt.cnt = 4'h0;
          end
        end
        CBT_SEG_PH1: begin
          if (s_r.cnt == ph1_eff - 4'h1) begin
            s_nxt.seg = CBT_SEG_PH2;
            s_nxt.cnt = 4'h0;
            s_nxt.sample_stb = 1'b1;
            s_nxt.bit_val = s_r.cfg2[CBT_SAM_BIT] ? vote : rx_now;
            s_nxt.rs_done = 1'b0;
          end
        end
        CBT_SEG_PH2: begin
          if (s_r.cnt == ph2_eff - 4'h1) begin
            s_nxt.seg = CBT_SEG_SYNC;
            s_nxt.cnt = 4'h0;
            s_nxt.ext = 3'h0;
            s_nxt.shrink = 3'h0;
            s_nxt.hs_bit = 1'b0;
            s_nxt.bit_start = 1'b1;
          end
        end
        default: begin
          s_nxt.seg = CBT_SEG_SYNC;
          s_nxt.cnt = 4'h0;
        end
      endcase
    end

    // edge handling takes priority over the normal quantum step
    if (fall_edge) begin
      if (BUS_IDLE_IN) begin
        s_nxt.seg = CBT_SEG_SYNC;
        s_nxt.cnt = 4'h0;
        s_nxt.presc = '0;
        s_nxt.half_ph = 1'b0;
        // the quarter divider restarts too, else the first quantum is short
        s_nxt.div = '0;
        s_nxt.ext = 3'h0;
        s_nxt.shrink = 3'h0;
        s_nxt.hs_bit = 1'b1;
        s_nxt.rs_done = 1'b1;
        s_nxt.bit_start = 1'b1;
        s_nxt.hard_sync = 1'b1;
        s_nxt.sample_stb = 1'b0;
        s_nxt.bit_val = s_r.bit_val;
      end else if (~s_r.rs_done & ~s_r.hs_bit) begin
        s_nxt.rs_done = 1'b1;
        case (s_r.seg)
          CBT_SEG_PROP: begin
            s_nxt.ext = adj;
          end
          CBT_SEG_PH1: begin
            s_nxt.ext = adj;
          end
          CBT_SEG_PH2: begin
            if (early_end) begin
              s_nxt.seg = CBT_SEG_SYNC;
              s_nxt.cnt = 4'h0;
              s_nxt.presc = '0;
              s_nxt.half_ph = 1'b0;
              s_nxt.div = '0;
              s_nxt.ext = 3'h0;
              s_nxt.shrink = 3'h0;
              s_nxt.bit_start = 1'b1;
            end else begin
              s_nxt.shrink = sjw_len[2:0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // a low clock enable freezes everything, bus handshake included
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      s_r <= '0;
      s_r.cfg1 <= CBT_CFG1_RST;
      s_r.cfg2 <= CBT_CFG2_RST;
      s_r.src_sel <= CBT_SRC_RST;
      s_r.seg <= CBT_SEG_SYNC;
      s_r.bit_val <= 1'b1;
    end else if (CE_IN) begin
      s_r <= s_nxt;
    end
  end

  assign WB_DAT_OUT = s_r.dat;
  assign WB_ACK_OUT = s_r.ack;
  assign SAMPLE_BIT_OUT = s_r.bit_val;
  assign SAMPLE_STROBE_OUT = s_r.sample_stb;
  assign BIT_START_OUT = s_r.bit_start;
  assign TQ_TICK_OUT = s_r.tq_tick;
  assign HARD_SYNC_OUT = s_r.hard_sync;

endmodule

`default_nettype wire

/* tb/cbt_sva.sv */
// port assertions for the can bit timing block
`default_nettype none

module cbt_sva (
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  // wishbone
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_ACK_OUT,
  // bus side
  input wire logic CAN_RX_IN,
  input wire logic BUS_IDLE_IN,
  input wire logic SAMPLE_STROBE_OUT,
  input wire logic BIT_START_OUT,
  input wire logic TQ_TICK_OUT,
  input wire logic HARD_SYNC_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);

  chk_hs_restart: assert property (HARD_SYNC_OUT |-> BIT_START_OUT)
    else $error("hard sync without bit start");
  chk_hs_idle: assert property (HARD_SYNC_OUT |-> $past(BUS_IDLE_IN))
    else $error("hard sync while bus busy");
  chk_hs_fall: assert property (HARD_SYNC_OUT |-> !$past(CAN_RX_IN, 3))
    else $error("hard sync without dominant level");
  chk_hs_nobit: assert property (HARD_SYNC_OUT |=> !BIT_START_OUT [*7])
    else $error("bit cut short after hard sync");
  chk_tq_gap: assert property (TQ_TICK_OUT ##1 !HARD_SYNC_OUT |-> !TQ_TICK_OUT)
    else $error("quantum shorter than two clocks");
  chk_strobe_once: assert property (SAMPLE_STROBE_OUT |=> !SAMPLE_STROBE_OUT)
    else $error("sample strobe longer than one cycle");
  chk_strobe_apart: assert property (BIT_START_OUT |-> !SAMPLE_STROBE_OUT)
    else $error("sample point inside sync segment");
  chk_ack_take: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("request not acknowledged");
  chk_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
endmodule

bind cbt_bit_timing cbt_sva chk (.CLOCK_IN, .ARST_N_IN, .WB_CYC_IN,
  .WB_STB_IN, .WB_ACK_OUT, .CAN_RX_IN, .BUS_IDLE_IN, .SAMPLE_STROBE_OUT,
  .BIT_START_OUT, .TQ_TICK_OUT, .HARD_SYNC_OUT);

`default_nettype wire

/* tb/cbt_can_node.sv */
// behavioural can node that drives the shared receive line
`default_nettype none

module cbt_can_node (
  // clock
  input wire logic clk_in,
  // bus level, 1 recessive
  output logic rx_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rx_out = 1'b1;

  // whole bits only; bit 1 may be stretched to push the next edge late
  task automatic send(input logic [7:0] bits, input int n, input int len,
                      input int late);
    for (int i = 0; i < n; i++) begin
      rx_out <= bits[i];
      repeat (len + ((i == 1) ? late : 0)) @(posedge clk_in);
    end
    // released line returns to recessive
    rx_out <= 1'b1;
  endtask
endmodule

`default_nettype wire

/* tb/can_bit_timing_logic_bench.sv */
// self-checking bench for the can bit timing block
`default_nettype none

module can_bit_timing_logic_bench
  import cbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic idle = 1'b1, ce = 1'b1, rx;
  logic [3:0] adr = 4'h0, sel = 4'hF;
  logic [31:0] dat = 32'h0, wbo, q, c1, c2;
  logic ack, sbit, sstr, bst, tqt, hs;
  int errors = 0, num_checks = 0, ncyc = 0;
  int tq, nq, prop, ph1, ph2, sjw, late, t0, n, presc, src, maj, sel2;

  always #20 clk = ~clk;

  cbt_bit_timing uut (.CLOCK_IN(clk), .ARST_N_IN(rst_n), .CE_IN(ce),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(sel), .WB_DAT_IN(dat), .WB_DAT_OUT(wbo), .WB_ACK_OUT(ack),
    .CAN_RX_IN(rx), .BUS_IDLE_IN(idle), .SAMPLE_BIT_OUT(sbit),
    .SAMPLE_STROBE_OUT(sstr), .BIT_START_OUT(bst), .TQ_TICK_OUT(tqt),
    .HARD_SYNC_OUT(hs));
  cbt_can_node node (.clk_in(clk), .rx_out(rx));

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk) begin
    ncyc <= ncyc + 1;
    if (ncyc == 80000) begin
      errors++;
      stop_test();
    end
  end

  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: value %h not %h", $time, g, e);
    end
  endtask

  task automatic cmp_time(input int g, input int e);
    num_checks++;
    if (g != e) begin
      errors++;
      $display("unexpected at %0t: count %0d not %0d", $time, g, e);
    end
  endtask

  // classic single cycle; holds the request until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = wbo;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  // 0 sample strobe, 1 bit start, 2 hard sync
  task automatic wait_evt(input int k);
    do @(posedge clk);
    while (((k == 0) ? sstr : (k == 1) ? bst : hs) !== 1'b1);
  endtask

  initial begin
    void'($urandom(85582));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, CBT_OFS_CFG1, 0);
    cmp_val(q, {24'h0, CBT_CFG1_RST});
    wb(1'b0, CBT_OFS_CFG2, 0);
    cmp_val(q, {21'h0, CBT_CFG2_RST});
    wb(1'b0, CBT_OFS_CTRL, 0);
    cmp_val(q, {31'h0, CBT_SRC_RST});
    wb(1'b1, 4'h2, 32'hFFFFFFFF);
    wb(1'b0, 4'h2, 0);
    cmp_val(q, 32'h0);
    wb(1'b0, CBT_OFS_CFG1, 0);
    cmp_val(q, 32'h0);
    for (int i = 0; i < 6; i++) begin
      // sample point kept late in the bit, ph2 above the jump width
      prop = 5 + $urandom % 4;
      ph1 = 1 + $urandom % 3;
      sel2 = $urandom % 2;
      sjw = 1 + $urandom % 4;
      ph2 = sel2 ? 5 + $urandom % 2 : ((ph1 > 2) ? ph1 : 2);
      if (sel2 == 0) sjw = 1 + $urandom % (ph2 - 1);
      presc = (i == 5) ? 63 : $urandom % 2;
      src = (i == 5) ? 0 : $urandom % 2;
      maj = $urandom % 2;
      late = 1 + $urandom % 4;
      tq = 2 * (presc + 1) * (src ? 4 : 1);
      nq = 1 + prop + ph1 + ph2;
      c1 = ((sjw - 1) << CBT_SJW_LSB) | presc;
      c2 = (prop - 1) | ((ph1 - 1) << CBT_PH1_LSB) | (maj << CBT_SAM_BIT)
        | (sel2 << CBT_PH2SEL_BIT)
        | ((sel2 ? ph2 - 1 : $urandom % 8) << CBT_PH2_LSB);
      idle <= 1'b1;
      wb(1'b1, CBT_OFS_CFG1, c1);
      wb(1'b1, CBT_OFS_CFG2, c2);
      wb(1'b1, CBT_OFS_CTRL, src);
      wb(1'b0, CBT_OFS_CFG2, 0);
      cmp_val(q, c2);
      fork
        node.send(8'h1A, 5, nq * tq, late * tq);
        begin
          wait_evt(2);
          // frame logic leaves idle once the message has started
          idle <= 1'b0;
          t0 = ncyc;
          for (int b = 0; b < 4; b++) begin
            // a late edge lands on a quantum step: it counts one quantum less
            n = (b != 2) ? 0 : (late - 1 < sjw) ? late - 1 : sjw;
            wait_evt(0);
            cmp_time(ncyc - t0, (1 + prop + ph1 + n) * tq);
            @(posedge clk);
            cmp_val({31'h0, sbit}, b % 2);
            wait_evt(1);
            cmp_time(ncyc - t0, (nq + n) * tq);
            t0 = ncyc;
          end
        end
      join
    end
    n = 0;
    fork
      node.send(8'h1A, 5, nq * tq, 0);
      repeat (6 * nq * tq) begin
        @(posedge clk);
        if (hs === 1'b1) n++;
      end
    join
    cmp_time(n, 0);
    stop_test();
  end
endmodule

`default_nettype wire
